// file: timer16_consts.vh
// constants for the 16-bit timer waveform generator and its register map
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define T16_ADDR_CTRL      8'h00
`define T16_ADDR_COUNT     8'h04
`define T16_ADDR_CMPA      8'h08
`define T16_ADDR_CMPB      8'h0C
`define T16_ADDR_CAPT      8'h10
`define T16_ADDR_FLAGS     8'h14
`define T16_ADDR_PORT      8'h18
`define T16_ADDR_PRESCALE  8'h1C
// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define T16_CTRL_WGM_LSB   0
`define T16_CTRL_COMA_LSB  4
`define T16_CTRL_COMB_LSB  6
`define T16_CTRL_FOCA_BIT  8
`define T16_CTRL_FOCB_BIT  9
`define T16_CTRL_EN_BIT    10
// ----------------------------------------------------------------------
// flag register bits
// ----------------------------------------------------------------------
`define T16_FLAG_OVF_BIT   0
`define T16_FLAG_CMPA_BIT  1
`define T16_FLAG_CMPB_BIT  2
`define T16_FLAG_CAPT_BIT  3
// ----------------------------------------------------------------------
// port register bits
// ----------------------------------------------------------------------
`define T16_PORT_DIRA_BIT  0
`define T16_PORT_DIRB_BIT  1
`define T16_PORT_OUTA_BIT  2
`define T16_PORT_OUTB_BIT  3
`define T16_PORT_STA_BIT   4
`define T16_PORT_STB_BIT   5
// ----------------------------------------------------------------------
// waveform modes, output modes, fixed tops, reset values
// ----------------------------------------------------------------------
`define T16_WGM_NORMAL     4'h0
`define T16_WGM_CLR_CMP    4'h4
`define T16_WGM_FAST8      4'h5
`define T16_WGM_FAST9      4'h6
`define T16_WGM_FAST10     4'h7
`define T16_WGM_CLR_CAPT   4'hC
`define T16_WGM_FAST_CAPT  4'hE
`define T16_WGM_FAST_CMP   4'hF
`define T16_COM_OFF        2'h0
`define T16_COM_TOGGLE     2'h1
`define T16_COM_CLEAR      2'h2
`define T16_COM_SET        2'h3
`define T16_MAX            16'hFFFF
`define T16_BOTTOM         16'h0000
`define T16_TOP8           16'h00FF
`define T16_TOP9           16'h01FF
`define T16_TOP10          16'h03FF
`define T16_RESP_OKAY      2'h0
`define T16_RESP_SLVERR    2'h2
`define T16_PRESCALE_RST   16'h0000
`endif

// file: clock_tick.v
// prescaler producing the one-cycle timer clock enable
`timescale 1ns/10ps
module clock_tick #(
    parameter W = 16
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] divide,
    output reg          tick_q
);
    reg [W-1:0] cnt_q;

    // divide of 0 gives a tick every cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q >= divide) begin
            cnt_q  <= {W{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end
endmodule // clock_tick

// file: compare_out.v
// one compare output unit: internal output state and pin override
`timescale 1ns/10ps
`include "timer16_consts.vh"
module compare_out (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       match,
    input  wire       at_top,
    input  wire       force_strobe,
    input  wire       pwm,
    input  wire [1:0] mode,
    input  wire       pin_direction,
    input  wire       port_value,
    output reg        state_q,
    output reg        pin_out_q,
    output reg        pin_oe_q
);
    reg state_d;

    always @* begin
        state_d = state_q;
        if (pwm) begin
            // toggle in pwm only applies where the caller allows it
            if (mode == `T16_COM_TOGGLE && match)
                state_d = ~state_q;
            else if (mode == `T16_COM_CLEAR) begin
                if (match)
                    state_d = 1'b1;
                else if (at_top)
                    state_d = 1'b0;
            end else if (mode == `T16_COM_SET) begin
                if (match)
                    state_d = 1'b0;
                else if (at_top)
                    state_d = 1'b1;
            end
        end else if (match || force_strobe) begin
            case (mode)
                `T16_COM_TOGGLE: state_d = ~state_q;
                `T16_COM_CLEAR:  state_d = 1'b0;
                `T16_COM_SET:    state_d = 1'b1;
                default:         state_d = state_q;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            pin_out_q <= (mode != `T16_COM_OFF) ? state_d : port_value;
            pin_oe_q  <= pin_direction;
        end
    end
endmodule // compare_out

// file: timer16_waveform_modes.v
// 16-bit timer waveform generator with axi4-lite register slave
`timescale 1ns/10ps
`include "timer16_consts.vh"
// Notes on behaviour
// - output mode zero leaves the output state unchanged at a match.
// - new output mode acts at next match; force strobe acts at once outside pwm.
// - counting follows only the waveform mode; output mode only shapes output.
// - mode 0 counts up forever, wrapping from 0xFFFF to 0x0000.
// - mode 0 overflow flag sets as count becomes zero; software clears it.
// - mode 0 accepts a count write at any time.
// - clear-on-match clears at top: compare A in mode 4, capture in 12.
// - clear-on-match top unbuffered; top below count misses until wrap.
// - clear-on-match raises compare A or capture flag at each top.
// - clear-on-match with output mode 1 toggles output A each match.
// - output A reaches the pin only when its direction bit is one.
// - clear-on-match overflow flag sets when count passes max to zero.
// - modes 5,6,7,14,15 are fast pwm counting zero to top repeatedly.
// - fast pwm tops fixed, capture or compare A; clear cycle after top.
// - non-inverting sets at match, clears at top; inverting the opposite.
// - fast pwm sets a compare flag whenever count equals its value.
// - fast pwm overflow at top; compare A or capture flag too then when it gives top (modes 15, 14).
// - fixed top masks compare bits above top width on every write.
// - capture top unbuffered; value below count misses until wrap.
// - fast pwm compare A writes buffer, copied to active at top.
// - pwm output mode 2 non-inverted, mode 3 inverted.
// - reset clears internal output state to zero.
// - nonzero output mode replaces port value on the pin, except output mode 1 where it is inert in pwm for output B and for output A outside mode 15.
module timer16_waveform_modes (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        capture_event,
    output wire        compare_output_a,
    output wire        compare_output_a_oe,
    output wire        compare_output_b,
    output wire        compare_output_b_oe
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [3:0]  waveform_gen_mode_q;
    reg [1:0]  compare_output_mode_a_q;
    reg [1:0]  compare_output_mode_b_q;
    reg        enable_q;
    reg [15:0] count_value_q;
    reg [15:0] compare_value_a_q;
    reg [15:0] compare_buf_a_q;
    reg [15:0] compare_value_b_q;
    reg [15:0] compare_buf_b_q;
    reg [15:0] capture_value_q;
    reg        overflow_flag_q;
    reg        compare_flag_a_q;
    reg        compare_flag_b_q;
    reg        capture_flag_q;
    reg [3:0]  port_q;
    reg [15:0] prescale_q;
    reg        force_a_q;
    reg        force_b_q;
    reg        count_written_q;
    reg        cap_s1_q;
    reg        cap_s2_q;
    reg        cap_s3_q;
    reg        aw_held_q;
    reg        w_held_q;
    reg [7:0]  aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire tick;
    wire state_a;
    wire state_b;
    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    function is_fast_pwm;
        input [3:0] m;
        begin
            is_fast_pwm = (m == `T16_WGM_FAST8) || (m == `T16_WGM_FAST9) ||
                          (m == `T16_WGM_FAST10) || (m == `T16_WGM_FAST_CAPT) ||
                          (m == `T16_WGM_FAST_CMP);
        end
    endfunction
    // fixed-top mask; all ones when top comes from a register
    function [15:0] top_mask;
        input [3:0] m;
        begin
            case (m)
                `T16_WGM_FAST8:  top_mask = `T16_TOP8;
                `T16_WGM_FAST9:  top_mask = `T16_TOP9;
                `T16_WGM_FAST10: top_mask = `T16_TOP10;
                default:         top_mask = `T16_MAX;
            endcase
        end
    endfunction
    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0]  strb;
        begin
            merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction
    wire        fast     = is_fast_pwm(waveform_gen_mode_q);
    wire        top_capt = (waveform_gen_mode_q == `T16_WGM_CLR_CAPT) ||
                           (waveform_gen_mode_q == `T16_WGM_FAST_CAPT);
    wire        top_cmpa = (waveform_gen_mode_q == `T16_WGM_CLR_CMP) ||
                           (waveform_gen_mode_q == `T16_WGM_FAST_CMP);
    wire        clear_on_match = !fast && (top_capt || top_cmpa);
    // top source
    wire [15:0] top_value = top_capt ? capture_value_q :
                            top_cmpa ? compare_value_a_q :
                            fast     ? top_mask(waveform_gen_mode_q) : `T16_MAX;
    wire        timer_tick = tick && enable_q;
    // equality only, so a top written below the count is missed until wrap
    wire        at_top   = (fast || clear_on_match) && (count_value_q == top_value);
    wire        block    = count_written_q;
    wire        match_a  = timer_tick && !block && (count_value_q == compare_value_a_q);
    wire        match_b  = timer_tick && !block && (count_value_q == compare_value_b_q);
    wire        top_hit  = timer_tick && !block && at_top;
    wire        pwm_top  = fast && top_hit;
    wire        wrap     = timer_tick && (count_value_q == `T16_MAX);

    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    wire        do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    wire        wr_ctrl  = do_write && (aw_addr_q == `T16_ADDR_CTRL);
    wire        wr_count = do_write && (aw_addr_q == `T16_ADDR_COUNT);
    wire        wr_flags = do_write && (aw_addr_q == `T16_ADDR_FLAGS);
    wire        mapped_w = (aw_addr_q[7:5] == 3'h0) && (aw_addr_q[1:0] == 2'h0);
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `T16_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped_w ? `T16_RESP_OKAY : `T16_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            waveform_gen_mode_q     <= `T16_WGM_NORMAL;
            compare_output_mode_a_q <= `T16_COM_OFF;
            compare_output_mode_b_q <= `T16_COM_OFF;
            enable_q                <= 1'b0;
            force_a_q               <= 1'b0;
            force_b_q               <= 1'b0;
            compare_buf_a_q         <= 16'h0000;
            compare_buf_b_q         <= 16'h0000;
            port_q                  <= 4'h0;
            prescale_q              <= `T16_PRESCALE_RST;
        end else begin
            // mode changes reach the output logic at once but act only on the next match
            force_a_q <= wr_ctrl && w_strb_q[1] && w_data_q[`T16_CTRL_FOCA_BIT] && !fast;
            force_b_q <= wr_ctrl && w_strb_q[1] && w_data_q[`T16_CTRL_FOCB_BIT] && !fast;
            if (wr_ctrl && w_strb_q[0]) begin
                waveform_gen_mode_q     <= w_data_q[`T16_CTRL_WGM_LSB +: 4];
                compare_output_mode_a_q <= w_data_q[`T16_CTRL_COMA_LSB +: 2];
                compare_output_mode_b_q <= w_data_q[`T16_CTRL_COMB_LSB +: 2];
            end
            if (wr_ctrl && w_strb_q[1])
                enable_q <= w_data_q[`T16_CTRL_EN_BIT];
            if (do_write && aw_addr_q == `T16_ADDR_CMPA)
                compare_buf_a_q <= merge(compare_buf_a_q, w_data_q, w_strb_q) &
                                   top_mask(waveform_gen_mode_q);
            if (do_write && aw_addr_q == `T16_ADDR_CMPB)
                compare_buf_b_q <= merge(compare_buf_b_q, w_data_q, w_strb_q) &
                                   top_mask(waveform_gen_mode_q);
            if (do_write && aw_addr_q == `T16_ADDR_PORT && w_strb_q[0])
                port_q <= w_data_q[3:0];
            if (do_write && aw_addr_q == `T16_ADDR_PRESCALE)
                prescale_q <= merge(prescale_q, w_data_q, w_strb_q);
        end
    end

    // ------------------------------------------------------------------
    // counter, compare registers, capture
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_value_q     <= `T16_BOTTOM;
            count_written_q   <= 1'b0;
            compare_value_a_q <= 16'h0000;
            compare_value_b_q <= 16'h0000;
            capture_value_q   <= 16'h0000;
            cap_s1_q          <= 1'b0;
            cap_s2_q          <= 1'b0;
            cap_s3_q          <= 1'b0;
        end else begin
            cap_s1_q <= capture_event;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
            if (wr_count) begin
                count_value_q   <= merge(count_value_q, w_data_q, w_strb_q);
                count_written_q <= 1'b1;
            end else if (timer_tick) begin
                count_written_q <= 1'b0;
                if (top_hit)
                    count_value_q <= `T16_BOTTOM;
                else
                    count_value_q <= count_value_q + 16'h0001;
            end
            // unbuffered outside pwm; pwm copies the buffer at top
            if (!fast || pwm_top) begin
                compare_value_a_q <= compare_buf_a_q;
                compare_value_b_q <= compare_buf_b_q;
            end
            if (do_write && aw_addr_q == `T16_ADDR_CAPT)
                capture_value_q <= merge(capture_value_q, w_data_q, w_strb_q);
            else if (!top_capt && cap_s2_q && !cap_s3_q)
                capture_value_q <= count_value_q;
        end
    end

    // ------------------------------------------------------------------
    // flags: write one to clear, a set in the same cycle wins
    // ------------------------------------------------------------------
    wire [3:0] clr = wr_flags && w_strb_q[0] ? w_data_q[3:0] : 4'h0;
    // normal/clear-on-match: overflow on wrap to zero; fast pwm: at top
    wire set_ovf  = fast ? pwm_top : wrap;
    wire set_cmpa = match_a || (top_hit && top_cmpa);
    wire set_capt = (top_hit && top_capt) ||
                    (!top_capt && cap_s2_q && !cap_s3_q);
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_flag_q  <= 1'b0;
            compare_flag_a_q <= 1'b0;
            compare_flag_b_q <= 1'b0;
            capture_flag_q   <= 1'b0;
        end else begin
            overflow_flag_q  <= set_ovf  || (overflow_flag_q  && !clr[`T16_FLAG_OVF_BIT]);
            compare_flag_a_q <= set_cmpa || (compare_flag_a_q && !clr[`T16_FLAG_CMPA_BIT]);
            compare_flag_b_q <= match_b  || (compare_flag_b_q && !clr[`T16_FLAG_CMPB_BIT]);
            capture_flag_q   <= set_capt || (capture_flag_q   && !clr[`T16_FLAG_CAPT_BIT]);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `T16_ADDR_CTRL:     rd_mux = {21'h0, enable_q, 2'h0, compare_output_mode_b_q,
                                          compare_output_mode_a_q, waveform_gen_mode_q};
            `T16_ADDR_COUNT:    rd_mux = {16'h0000, count_value_q};
            `T16_ADDR_CMPA:     rd_mux = {16'h0000, compare_buf_a_q};
            `T16_ADDR_CMPB:     rd_mux = {16'h0000, compare_buf_b_q};
            `T16_ADDR_CAPT:     rd_mux = {16'h0000, capture_value_q};
            `T16_ADDR_FLAGS:    rd_mux = {28'h0000000, capture_flag_q, compare_flag_b_q,
                                          compare_flag_a_q, overflow_flag_q};
            `T16_ADDR_PORT:     rd_mux = {26'h0, state_b, state_a, port_q};
            `T16_ADDR_PRESCALE: rd_mux = {16'h0000, prescale_q};
            default:            rd_mux = 32'h00000000;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `T16_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0) ?
                                `T16_RESP_OKAY : `T16_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // prescaler and output units
    // ------------------------------------------------------------------
    clock_tick #(.W(16)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .divide  (prescale_q),
        .tick_q  (tick)
    );
    // toggle in pwm only for unit a with compare a as top; else mode 1 is inert
    wire [1:0] com_a_eff = (fast && compare_output_mode_a_q == `T16_COM_TOGGLE &&
                            waveform_gen_mode_q != `T16_WGM_FAST_CMP) ?
                           `T16_COM_OFF : compare_output_mode_a_q;
    wire [1:0] com_b_eff = (fast && compare_output_mode_b_q == `T16_COM_TOGGLE) ?
                           `T16_COM_OFF : compare_output_mode_b_q;
    compare_out u_out_a (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .match         (match_a),
        .at_top        (pwm_top),
        .force_strobe  (force_a_q),
        .pwm           (fast),
        .mode          (com_a_eff),
        .pin_direction (port_q[`T16_PORT_DIRA_BIT]),
        .port_value    (port_q[`T16_PORT_OUTA_BIT]),
        .state_q       (state_a),
        .pin_out_q     (compare_output_a),
        .pin_oe_q      (compare_output_a_oe)
    );

    compare_out u_out_b (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .match         (match_b),
        .at_top        (pwm_top),
        .force_strobe  (force_b_q),
        .pwm           (fast),
        .mode          (com_b_eff),
        .pin_direction (port_q[`T16_PORT_DIRB_BIT]),
        .port_value    (port_q[`T16_PORT_OUTB_BIT]),
        .state_q       (state_b),
        .pin_out_q     (compare_output_b),
        .pin_oe_q      (compare_output_b_oe)
    );
endmodule // timer16_waveform_modes

// file: timer16_waveform_modes_monitor.sv
// checker for the bus handshakes and the compare output after reset
`timescale 1ns/10ps
module wave_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        compare_output_a,
    input wire        compare_output_a_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
        else $error("bad write response code");
    a_state_cleared: assert property ($rose(aresetn) |-> !compare_output_a && !compare_output_a_oe)
        else $error("compare output not cleared by reset");
endmodule // wave_monitor
bind timer16_waveform_modes wave_monitor i_wave_monitor (.*);

// file: pin_load.sv
// external load on compare pin a: pull-down, counts rising edges
`timescale 1ns/10ps
module pin_load (
    input  wire pin,
    input  wire oe,
    output integer edges
);
    // undriven pin falls to the pull-down level
    wire level = oe ? pin : 1'b0;
    initial edges = 0;
    always @(posedge level) edges = edges + 1;
endmodule // pin_load

// file: timer16_waveform_modes_test.sv
// self-checking bench for the timer waveform generator
`timescale 1ns/10ps
`include "timer16_consts.vh"
module timer16_waveform_modes_test;
    reg aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0, capture_event = 0;
    reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0, r;
    reg [3:0] s_axi_wstrb = 4'h3;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire compare_output_a, compare_output_a_oe, compare_output_b, compare_output_b_oe;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer failures = 0, checks = 0, edges;
    reg [33:0] q[$];
    initial forever #50 aclk = ~aclk;
    timer16_waveform_modes i_timer16_waveform_modes (.*);
    pin_load i_pin_load (.pin(compare_output_a), .oe(compare_output_a_oe), .edges(edges));
    task chk(input string n, input [33:0] x, input [33:0] y);
        checks++;
        if (x !== y) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, x, y);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        chk("bresp", `T16_RESP_OKAY, s_axi_bresp);
        s_axi_bready <= 0;
    endtask
    // expectation queued before the request, compared by the watcher below
    task rd(input [7:0] a, input [33:0] e);
        q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
    endtask
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk("rdata", q.pop_front(), {s_axi_rresp, s_axi_rdata});
    task give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2000000 failures++;
        give_verdict;
    end
    initial begin
        r = $urandom(42);
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        rd(`T16_ADDR_PORT, 0);
        rd(8'h20, {`T16_RESP_SLVERR, 32'h0});
        r = $urandom & 32'hFFFF;
        wr(`T16_ADDR_COUNT, r);
        rd(`T16_ADDR_COUNT, r);
        wr(`T16_ADDR_CTRL, 32'h5);
        wr(`T16_ADDR_CMPA, 32'h1234);
        rd(`T16_ADDR_CMPA, 32'h34);
        wr(`T16_ADDR_PORT, 1);
        wr(`T16_ADDR_CTRL, 32'h30);
        wr(`T16_ADDR_CTRL, 32'h130);
        rd(`T16_ADDR_PORT, 32'h11);
        wr(`T16_ADDR_CTRL, 32'h120);
        rd(`T16_ADDR_PORT, 32'h01);
        $display("test setup and force done");
        wr(`T16_ADDR_CMPB, 32'hFFFF);
        wr(`T16_ADDR_COUNT, 0);
        wr(`T16_ADDR_CMPA, 3);
        wr(`T16_ADDR_FLAGS, 32'hF);
        wr(`T16_ADDR_CTRL, 32'h414);
        repeat (40) @(posedge aclk);
        wr(`T16_ADDR_CTRL, 32'h014);
        rd(`T16_ADDR_FLAGS, 32'h2);
        chk("edges", edges > 2, 1);
        $display("test clear on match done");
        wr(`T16_ADDR_CTRL, 0);
        wr(`T16_ADDR_CMPA, 32'h8000);
        wr(`T16_ADDR_CMPB, 32'h8000);
        wr(`T16_ADDR_COUNT, 32'hFFFE);
        wr(`T16_ADDR_FLAGS, 32'hF);
        wr(`T16_ADDR_CTRL, 32'h400);
        repeat (10) @(posedge aclk);
        wr(`T16_ADDR_CTRL, 0);
        rd(`T16_ADDR_FLAGS, 32'h1);
        $display("test normal wrap done");
        wr(`T16_ADDR_PORT, 32'hB);
        wr(`T16_ADDR_CMPA, 2);
        wr(`T16_ADDR_CMPB, 7);
        wr(`T16_ADDR_CAPT, 7);
        wr(`T16_ADDR_COUNT, 0);
        wr(`T16_ADDR_FLAGS, 32'hF);
        r = edges;
        wr(`T16_ADDR_CTRL, 32'h4EE);
        repeat (40) @(posedge aclk);
        wr(`T16_ADDR_CTRL, 32'h0EE);
        chk("edges pwm", edges - r > 2, 1);
        chk("pin b", {compare_output_b_oe, compare_output_b}, 2'b10);
        wr(`T16_ADDR_CTRL, 32'h02E);
        rd(`T16_ADDR_FLAGS, 32'hF);
        chk("pin b port", {compare_output_b_oe, compare_output_b}, 2'b11);
        $display("test fast pwm done");
        give_verdict;
    end
endmodule // timer16_waveform_modes_test
